// ===== core/cal_engine.sv
// calibration sequencer for one converter: active, fail and done flags
// assumes one start pulse per launch and a static divider during a run
`timescale 1ns/1ps
module cal_engine
   import dac_cal_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_start,
   input wire logic [DIV_WIDTH-1:0] i_divider,
   input wire logic i_clock_powerdown,
   input wire logic i_fault,
   output logic o_active,
   output logic o_fail,
   output logic o_done
);

   cal_state_t state_reg;
   logic [DIV_WIDTH-1:0] tick_reg;
   logic [STEP_WIDTH-1:0] step_reg;
   logic run_end;
   logic run_bad;

   // a run ends on the last divided step, or at once if its clock stops
   assign run_end = (state_reg == CAL_RUN) &&
      (i_clock_powerdown || (tick_reg == i_divider && step_reg == CAL_LAST_STEP));
   assign run_bad = i_clock_powerdown || i_fault;

   // sequencer and step counters; a low enable holds the engine in reset
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || !i_enable)
      begin
         state_reg <= CAL_IDLE;
         tick_reg <= '0;
         step_reg <= '0;
      end
      else
      begin
         unique case (state_reg)
            CAL_IDLE:
            begin
               tick_reg <= '0;
               step_reg <= '0;
               if (i_start)
                  state_reg <= CAL_RUN;
            end
            CAL_RUN:
            begin
               if (run_end)
                  state_reg <= CAL_IDLE;
               else if (tick_reg == i_divider)
               begin
                  tick_reg <= '0;
                  step_reg <= step_reg + 1'b1;
               end
               else
                  tick_reg <= tick_reg + 1'b1;
            end
         endcase
      end
   end

   // result flags; active drops in the same edge that a result is posted
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || !i_enable)
      begin
         o_active <= 1'b0;
         o_fail <= 1'b0;
         o_done <= 1'b0;
      end
      else if (state_reg == CAL_IDLE && i_start)
      begin
         o_active <= 1'b1;
         o_fail <= 1'b0;
         o_done <= 1'b0;
      end
      else if (run_end)
      begin
         o_active <= 1'b0;
         o_fail <= run_bad;
         o_done <= !run_bad;
      end
   end

   hold_reset_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_enable |=> !o_active && !o_fail && !o_done)
      else $error("engine not held in reset while disabled");

   active_rise_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_enable && state_reg == CAL_IDLE && i_start) |=> o_active && !o_done && !o_fail)
      else $error("active flag missing after launch");

   end_exclusive_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n || !i_enable)
      $fell(o_active) |-> (o_done != o_fail))
      else $error("run ended without exactly one result flag");

   done_timing_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_done) |-> $fell(o_active) && !o_fail)
      else $error("done flag rose outside a run end");

   clock_stop_fail_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_enable && o_active && i_clock_powerdown) |=> o_fail && !o_active)
      else $error("stopped calibration clock not reported as failure");

endmodule

// ===== core/dac_cal_pkg.sv
// constants and types shared by the calibration control and transmit mute logic
// assumes a single 10 MHz clock domain and an Avalon-MM register port
package dac_cal_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int REG_WIDTH = 8;
   localparam int BUS_WIDTH = 32;
   localparam int ADDR_WIDTH = 12;
   localparam int INDEX_WIDTH = 10;
   localparam int BE_WIDTH = 4;
   localparam int CONV_COUNT = 2;
   localparam int SAMPLE_WIDTH = 16;
   localparam int DIV_WIDTH = 4;
   localparam int STEP_WIDTH = 5;

   // ----------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [INDEX_WIDTH-1:0] IDX_PAGE = 10'h008;
   localparam logic [INDEX_WIDTH-1:0] IDX_TX_MUTE = 10'h03f;
   localparam logic [INDEX_WIDTH-1:0] IDX_CAL_DIV = 10'h050;
   localparam logic [INDEX_WIDTH-1:0] IDX_CAL_CTRL = 10'h051;
   localparam logic [INDEX_WIDTH-1:0] IDX_CAL_STAT = 10'h052;
   localparam logic [INDEX_WIDTH-1:0] IDX_FULL_SCALE = 10'h05a;
   localparam logic [INDEX_WIDTH-1:0] IDX_CAL_DEBUG = 10'h061;
   localparam logic [INDEX_WIDTH-1:0] IDX_CLK_CTRL = 10'h081;
   localparam logic [1:0] BYTE_LANE_ZERO = 2'h0;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_START_BIT = 0;
   localparam int STAT_ACTIVE_BIT = 2;
   localparam int STAT_FAIL_BIT = 1;
   localparam int STAT_DONE_BIT = 0;
   localparam int MUTE_DAC0_BIT = 4;
   localparam int DEBUG_TUNING_BIT = 6;

   // ----------------------------------------------------------------
   // reset values and masks
   // ----------------------------------------------------------------
   localparam logic [REG_WIDTH-1:0] PAGE_RESET = 8'h01;
   localparam logic [REG_WIDTH-1:0] TX_MUTE_RESET = 8'h00;
   localparam logic [REG_WIDTH-1:0] CAL_DIV_RESET = 8'h28;
   localparam logic [REG_WIDTH-1:0] CAL_CTRL_RESET = 8'h82;
   localparam logic [REG_WIDTH-1:0] CAL_CTRL_MASK = 8'h87;
   localparam logic [REG_WIDTH-1:0] FULL_SCALE_RESET = 8'h28;
   localparam logic [REG_WIDTH-1:0] CAL_DEBUG_RESET = 8'h40;
   localparam logic [REG_WIDTH-1:0] CLK_CTRL_RESET = 8'h00;
   localparam logic [REG_WIDTH-1:0] CLK_CTRL_MASK = 8'h03;
   localparam logic [STEP_WIDTH-1:0] CAL_LAST_STEP = 5'h1f;
   localparam logic [SAMPLE_WIDTH-1:0] SAMPLE_ZERO = 16'h0000;

   typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;

endpackage

// ===== core/dac_cal_tx_mute.sv
// register map, paged calibration control and first converter transmit mute
// assumes an Avalon-MM master with byte addresses and a single 10 MHz clock
`timescale 1ns/1ps

module dac_cal_tx_mute
   import dac_cal_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [ADDR_WIDTH-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [BUS_WIDTH-1:0] i_avs_writedata,
   input wire logic [BE_WIDTH-1:0] i_avs_byteenable,
   output logic [BUS_WIDTH-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_transmit_gate_pin_0,
   input wire logic [SAMPLE_WIDTH-1:0] i_dac0_data,
   output logic [SAMPLE_WIDTH-1:0] o_dac0_data,
   input wire logic i_cal_fault_0,
   input wire logic i_cal_fault_1,
   output logic [REG_WIDTH-1:0] o_full_scale_code_0,
   output logic [REG_WIDTH-1:0] o_full_scale_code_1,
   output logic o_cal_clock_powerdown_0,
   output logic o_cal_clock_powerdown_1,
   output logic o_cal_tuning_bit_a
);

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------

   logic ack_reg;
   logic request;
   logic write_take;
   logic read_capture;

   // true when a byte address hits the given register index
   function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr,
                                    input logic [INDEX_WIDTH-1:0] index);
      reg_hit = (addr[1:0] == BYTE_LANE_ZERO) && (addr[ADDR_WIDTH-1:2] == index);
   endfunction

   // every access takes exactly one wait state
   assign request = i_avs_read || i_avs_write;
   assign o_avs_waitrequest = request && !ack_reg;
   assign read_capture = i_avs_read && !ack_reg;
   assign write_take = i_avs_write && ack_reg && i_avs_byteenable[0];

   // ack alternates so that back to back requests each see one wait
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= request && !ack_reg;
   end

   // ----------------------------------------------------------------
   // shared registers
   // ----------------------------------------------------------------

   logic [REG_WIDTH-1:0] page_reg;
   logic [REG_WIDTH-1:0] tx_mute_reg;
   logic [REG_WIDTH-1:0] cal_div_reg;
   logic [REG_WIDTH-1:0] cal_debug_reg;
   logic [REG_WIDTH-1:0] clk_ctrl_reg;
   logic [REG_WIDTH-1:0] wdata;

   assign wdata = i_avs_writedata[REG_WIDTH-1:0];

   // page select: bit 0 reaches converter 0, bit 1 converter 1
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         page_reg <= PAGE_RESET;
      else if (write_take && reg_hit(i_avs_address, IDX_PAGE))
         page_reg <= wdata;
   end

   // transmit mute configuration
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         tx_mute_reg <= TX_MUTE_RESET;
      else if (write_take && reg_hit(i_avs_address, IDX_TX_MUTE))
         tx_mute_reg <= wdata;
   end

   // calibration clock divider, low nibble paces the engine steps
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         cal_div_reg <= CAL_DIV_RESET;
      else if (write_take && reg_hit(i_avs_address, IDX_CAL_DIV))
         cal_div_reg <= wdata;
   end

   // calibration debug byte
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         cal_debug_reg <= CAL_DEBUG_RESET;
      else if (write_take && reg_hit(i_avs_address, IDX_CAL_DEBUG))
         cal_debug_reg <= wdata;
   end

   // calibration clock power-down bits, one per converter
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         clk_ctrl_reg <= CLK_CTRL_RESET;
      else if (write_take && reg_hit(i_avs_address, IDX_CLK_CTRL))
         clk_ctrl_reg <= wdata & CLK_CTRL_MASK;
   end

   assign o_cal_tuning_bit_a = cal_debug_reg[DEBUG_TUNING_BIT];
   assign o_cal_clock_powerdown_0 = clk_ctrl_reg[0];
   assign o_cal_clock_powerdown_1 = clk_ctrl_reg[1];

   // ----------------------------------------------------------------
   // per converter copies and calibration engines
   // ----------------------------------------------------------------

   logic [REG_WIDTH-1:0] cal_ctrl_reg [CONV_COUNT];
   logic [REG_WIDTH-1:0] full_scale_reg [CONV_COUNT];
   logic [REG_WIDTH-1:0] cal_stat [CONV_COUNT];
   logic [CONV_COUNT-1:0] start_pulse;
   logic [CONV_COUNT-1:0] cal_active;
   logic [CONV_COUNT-1:0] cal_fail;
   logic [CONV_COUNT-1:0] cal_done;
   logic [CONV_COUNT-1:0] cal_fault;

   assign cal_fault = {i_cal_fault_1, i_cal_fault_0};

   genvar k;
   generate
      for (k = 0; k < CONV_COUNT; k++)
      begin : g_conv
         // control copy written only when its page bit is set
         always_ff @(posedge i_clock)
         begin
            if (!i_rst_n)
               cal_ctrl_reg[k] <= CAL_CTRL_RESET;
            else if (write_take && page_reg[k] && reg_hit(i_avs_address, IDX_CAL_CTRL))
               cal_ctrl_reg[k] <= wdata & CAL_CTRL_MASK;
         end

         // full-scale code copy; current is 15.625 mA + code * 25/256 mA
         always_ff @(posedge i_clock)
         begin
            if (!i_rst_n)
               full_scale_reg[k] <= FULL_SCALE_RESET;
            else if (write_take && page_reg[k] && reg_hit(i_avs_address, IDX_FULL_SCALE))
               full_scale_reg[k] <= wdata;
         end

         // a write with the start bit set launches this converter's run if the engine is idle and its enable bit was already set
         assign start_pulse[k] = write_take && page_reg[k] &&
            reg_hit(i_avs_address, IDX_CAL_CTRL) && wdata[CTRL_START_BIT];

         // status byte, upper bits read as zero
         always_comb
         begin
            cal_stat[k] = '0;
            cal_stat[k][STAT_ACTIVE_BIT] = cal_active[k];
            cal_stat[k][STAT_FAIL_BIT] = cal_fail[k];
            cal_stat[k][STAT_DONE_BIT] = cal_done[k];
         end

         cal_engine u_cal_engine
         (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_enable(cal_ctrl_reg[k][CTRL_ENABLE_BIT]),
            .i_start(start_pulse[k]),
            .i_divider(cal_div_reg[DIV_WIDTH-1:0]),
            .i_clock_powerdown(clk_ctrl_reg[k]),
            .i_fault(cal_fault[k]),
            .o_active(cal_active[k]),
            .o_fail(cal_fail[k]),
            .o_done(cal_done[k])
         );
      end
   endgenerate

   assign o_full_scale_code_0 = full_scale_reg[0];
   assign o_full_scale_code_1 = full_scale_reg[1];

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------

   logic read_page;
   logic [REG_WIDTH-1:0] read_next;

   // paged reads come from converter 0 unless only page bit 1 is set
   assign read_page = !page_reg[0] && page_reg[1];

   // register byte for the current address; unmapped reads return zero
   always_comb
   begin
      read_next = '0;
      if (reg_hit(i_avs_address, IDX_PAGE))
         read_next = page_reg;
      else if (reg_hit(i_avs_address, IDX_TX_MUTE))
         read_next = tx_mute_reg;
      else if (reg_hit(i_avs_address, IDX_CAL_DIV))
         read_next = cal_div_reg;
      else if (reg_hit(i_avs_address, IDX_CAL_CTRL))
         read_next = cal_ctrl_reg[read_page];
      else if (reg_hit(i_avs_address, IDX_CAL_STAT))
         read_next = cal_stat[read_page];
      else if (reg_hit(i_avs_address, IDX_FULL_SCALE))
         read_next = full_scale_reg[read_page];
      else if (reg_hit(i_avs_address, IDX_CAL_DEBUG))
         read_next = cal_debug_reg;
      else if (reg_hit(i_avs_address, IDX_CLK_CTRL))
         read_next = clk_ctrl_reg;
   end

   // read data captured at the edge that ends the wait cycle, one edge before the completing edge
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         o_avs_readdata <= '0;
      else if (read_capture)
         o_avs_readdata <= {{(BUS_WIDTH-REG_WIDTH){1'b0}}, read_next};
   end

   // ----------------------------------------------------------------
   // first converter datapath mute
   // ----------------------------------------------------------------

   tx_datapath_mute u_tx_datapath_mute
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_mute_select(tx_mute_reg[MUTE_DAC0_BIT]),
      .i_gate_pin(i_transmit_gate_pin_0),
      .i_data(i_dac0_data),
      .o_data(o_dac0_data)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------

   one_wait_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (request && !ack_reg) |=> !o_avs_waitrequest)
      else $error("request not answered after one wait state");

   start_launch_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (start_pulse[0] && cal_ctrl_reg[0][CTRL_ENABLE_BIT] && !cal_active[0] && !cal_done[0]
         && !cal_fail[0]) |=> cal_active[0])
      else $error("start write did not launch converter 0");

   page_isolation_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && !page_reg[1] && reg_hit(i_avs_address, IDX_FULL_SCALE))
         |=> $stable(o_full_scale_code_1))
      else $error("unpaged full-scale copy changed");

   full_scale_load_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && page_reg[0] && reg_hit(i_avs_address, IDX_FULL_SCALE))
         |=> o_full_scale_code_0 == $past(wdata))
      else $error("full-scale code not loaded");

   status_read_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (read_capture && reg_hit(i_avs_address, IDX_CAL_STAT) && page_reg[0])
         |=> o_avs_readdata[STAT_ACTIVE_BIT] == $past(cal_active[0])
            && o_avs_readdata[STAT_DONE_BIT] == $past(cal_done[0]))
      else $error("status read does not show converter 0 flags");

   // converter 1 launches from its own start write
   conv1_launch_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (start_pulse[1] && cal_ctrl_reg[1][CTRL_ENABLE_BIT] && !cal_active[1]) |=> cal_active[1])
      else $error("start write did not launch converter 1");

   // a control write with page bit 0 clear leaves converter 0 alone
   ctrl_isolation_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && !page_reg[0] && reg_hit(i_avs_address, IDX_CAL_CTRL))
         |=> $stable(cal_ctrl_reg[0]))
      else $error("unpaged control copy changed");

   // converter 1 control copy takes the masked write byte
   ctrl_load_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && page_reg[1] && reg_hit(i_avs_address, IDX_CAL_CTRL))
         |=> cal_ctrl_reg[1] == ($past(wdata) & CAL_CTRL_MASK))
      else $error("converter 1 control copy not loaded");

   // converter 1 full-scale code follows its paged write
   second_scale_load_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && page_reg[1] && reg_hit(i_avs_address, IDX_FULL_SCALE))
         |=> o_full_scale_code_1 == $past(wdata))
      else $error("converter 1 full-scale code not loaded");

   // status read with page 1 alone shows converter 1 flags
   second_status_read_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (read_capture && reg_hit(i_avs_address, IDX_CAL_STAT) && read_page)
         |=> o_avs_readdata[STAT_ACTIVE_BIT] == $past(cal_active[1])
            && o_avs_readdata[STAT_FAIL_BIT] == $past(cal_fail[1])
            && o_avs_readdata[STAT_DONE_BIT] == $past(cal_done[1]))
      else $error("status read does not show converter 1 flags");

   // failure flag of converter 0 reaches the read data
   fail_read_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (read_capture && reg_hit(i_avs_address, IDX_CAL_STAT) && !read_page)
         |=> o_avs_readdata[STAT_FAIL_BIT] == $past(cal_fail[0]))
      else $error("failure flag missing from status read");

   // divider byte follows its write
   divider_load_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && reg_hit(i_avs_address, IDX_CAL_DIV))
         |=> cal_div_reg == $past(wdata))
      else $error("divider not loaded");

   // clock power-down bits keep only the two defined lanes
   powerdown_load_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (write_take && reg_hit(i_avs_address, IDX_CLK_CTRL))
         |=> clk_ctrl_reg == ($past(wdata) & CLK_CTRL_MASK))
      else $error("clock power-down bits not loaded");

endmodule

// ===== core/tx_datapath_mute.sv
// output stage of the first converter datapath with pin controlled muting
// assumes the transmit gate pin is already synchronous to i_clock
`timescale 1ns/1ps
module tx_datapath_mute
   import dac_cal_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_mute_select,
   input wire logic i_gate_pin,
   input wire logic [SAMPLE_WIDTH-1:0] i_data,
   output logic [SAMPLE_WIDTH-1:0] o_data
);

   // zero the sample while muting is armed and the pin is low
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         o_data <= SAMPLE_ZERO;
      else if (i_mute_select && !i_gate_pin)
         o_data <= SAMPLE_ZERO;
      else
         o_data <= i_data;
   end

   mute_bypass_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_mute_select |=> o_data == $past(i_data))
      else $error("sample altered while muting is disarmed");

   mute_force_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_mute_select && !i_gate_pin) |=> o_data == SAMPLE_ZERO)
      else $error("sample not zeroed while gate pin low");

endmodule

// ===== tb/tb.sv
// self-checking bench for the calibration register map and first converter mute
// assumes the Avalon-MM port may insert wait states and a synchronous active-low reset
`timescale 1ns/1ps
module tb
   import dac_cal_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus and observation signals
   // ----------------------------------------------------------------
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [ADDR_WIDTH-1:0] i_avs_address = '0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [BUS_WIDTH-1:0] i_avs_writedata = '0;
   logic [BE_WIDTH-1:0] i_avs_byteenable = 4'h1;
   logic [BUS_WIDTH-1:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic i_transmit_gate_pin_0 = 1'b0;
   logic [SAMPLE_WIDTH-1:0] i_dac0_data = '0;
   logic [SAMPLE_WIDTH-1:0] o_dac0_data;
   logic i_cal_fault_0 = 1'b0;
   logic i_cal_fault_1 = 1'b0;
   logic [REG_WIDTH-1:0] o_full_scale_code_0;
   logic [REG_WIDTH-1:0] o_full_scale_code_1;
   logic o_cal_clock_powerdown_0;
   logic o_cal_clock_powerdown_1;
   logic o_cal_tuning_bit_a;
   int bad_count = 0;
   int checks = 0;
   logic [31:0] rd;

   always #50 i_clock = ~i_clock; // 10 MHz

   dac_cal_tx_mute dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_transmit_gate_pin_0(i_transmit_gate_pin_0),
      .i_dac0_data(i_dac0_data), .o_dac0_data(o_dac0_data), .i_cal_fault_0(i_cal_fault_0),
      .i_cal_fault_1(i_cal_fault_1), .o_full_scale_code_0(o_full_scale_code_0),
      .o_full_scale_code_1(o_full_scale_code_1),
      .o_cal_clock_powerdown_0(o_cal_clock_powerdown_0),
      .o_cal_clock_powerdown_1(o_cal_clock_powerdown_1),
      .o_cal_tuning_bit_a(o_cal_tuning_bit_a));

   // ----------------------------------------------------------------
   // verdict, comparison and bus tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("mismatches %0d, comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   // one request held until waitrequest is sampled low at a rising edge
   task automatic bus(input bit wr, input logic [9:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge i_clock);
      i_avs_address <= {idx, 2'h0};
      i_avs_writedata <= {24'h000000, wd};
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      @(posedge i_clock);
      while (o_avs_waitrequest !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge i_clock);
      end
      if (n >= 50)
         chk(32'h0, 32'h1);
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      // one more edge lets a completed write settle before outputs are compared
      @(posedge i_clock);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask

   task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h000000, exp});
   endtask

   // reads status until active drops, then compares the whole byte
   task automatic poll(input logic [7:0] exp);
      int n;
      n = 0;
      bus(1'b0, IDX_CAL_STAT, 8'h00);
      while (rd[STAT_ACTIVE_BIT] !== 1'b0 && n < 500)
      begin
         n++;
         bus(1'b0, IDX_CAL_STAT, 8'h00);
      end
      chk(rd, {24'h000000, exp});
   endtask

   task automatic mute(input logic pin, input logic [15:0] d, input logic [15:0] exp);
      @(posedge i_clock);
      i_transmit_gate_pin_0 <= pin;
      i_dac0_data <= d;
      @(posedge i_clock);
      @(negedge i_clock);
      chk(o_dac0_data, exp);
   endtask

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (30000) @(posedge i_clock);
      bad_count++;
      final_report();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'b1;
      // reset values of the map and of the converter 1 full-scale and tuning outputs
      rchk(IDX_PAGE, 8'h01);
      rchk(IDX_TX_MUTE, 8'h00);
      rchk(IDX_CAL_DIV, 8'h28);
      rchk(IDX_CAL_CTRL, 8'h82);
      rchk(IDX_CAL_STAT, 8'h00);
      rchk(IDX_FULL_SCALE, 8'h28);
      rchk(IDX_CAL_DEBUG, 8'h40);
      rchk(IDX_CLK_CTRL, 8'h00);
      chk(o_full_scale_code_1, 8'h28);
      chk(o_cal_tuning_bit_a, 1'b1);
      // unmapped place reads zero and drops writes
      wr(10'h3ff, 8'h5a);
      rchk(10'h3ff, 8'h00);
      wr(IDX_CAL_DIV, 8'h0a);
      rchk(IDX_CAL_DIV, 8'h0a);
      // full-scale code held per converter
      wr(IDX_FULL_SCALE, 8'h10);
      chk(o_full_scale_code_0, 8'h10);
      chk(o_full_scale_code_1, 8'h28);
      wr(IDX_PAGE, 8'h02);
      wr(IDX_FULL_SCALE, 8'hff);
      chk(o_full_scale_code_1, 8'hff);
      rchk(IDX_FULL_SCALE, 8'hff);
      // clean run on converter 0, faulty run on converter 1
      wr(IDX_PAGE, 8'h01);
      wr(IDX_CAL_CTRL, 8'h83);
      rchk(IDX_CAL_STAT, 8'h04);
      rchk(IDX_CAL_CTRL, 8'h83);
      poll(8'h01);
      // clock powered down after completion keeps the result
      wr(IDX_CLK_CTRL, 8'h01);
      chk(o_cal_clock_powerdown_0, 1'b1);
      rchk(IDX_CAL_STAT, 8'h01);
      wr(IDX_CLK_CTRL, 8'h00);
      i_cal_fault_1 <= 1'b1;
      wr(IDX_PAGE, 8'h02);
      rchk(IDX_CAL_STAT, 8'h00);
      wr(IDX_CAL_CTRL, 8'h83);
      rchk(IDX_CAL_STAT, 8'h04);
      poll(8'h02);
      i_cal_fault_1 <= 1'b0;
      wr(IDX_PAGE, 8'h01);
      rchk(IDX_CAL_STAT, 8'h01);
      wr(IDX_CAL_STAT, 8'hff);
      rchk(IDX_CAL_STAT, 8'h01);
      // clock powered down in mid-run ends it as a failure
      wr(IDX_CAL_CTRL, 8'h82);
      wr(IDX_CAL_CTRL, 8'h83);
      rchk(IDX_CAL_STAT, 8'h04);
      wr(IDX_CLK_CTRL, 8'h01);
      chk(o_cal_clock_powerdown_0, 1'b1);
      poll(8'h02);
      wr(IDX_CLK_CTRL, 8'h00);
      // engine held in reset clears flags and refuses a start
      wr(IDX_CAL_CTRL, 8'h00);
      rchk(IDX_CAL_STAT, 8'h00);
      wr(IDX_CAL_CTRL, 8'h01);
      rchk(IDX_CAL_STAT, 8'h00);
      rchk(IDX_CAL_STAT, 8'h00);
      // transmit gate muting of the first converter
      mute(1'b0, 16'h1234, 16'h1234);
      wr(IDX_TX_MUTE, 8'h10);
      rchk(IDX_TX_MUTE, 8'h10);
      mute(1'b0, 16'habcd, 16'h0000);
      mute(1'b1, 16'h5a5a, 16'h5a5a);
      mute(1'b0, 16'hffff, 16'h0000);
      wr(IDX_TX_MUTE, 8'h00);
      mute(1'b0, 16'h8001, 16'h8001);
      final_report();
   end
endmodule
